//--- rtl/hvm_route_ctrl.sv
/*
  High-voltage measurement route control: owns the measure enable, the route switch,
  gating of wake, GPIO and fail-output functions, pull currents and the related status.
  Assumes a mode controller supplies the operating mode and a sleep request pulse, and
  that software uses the plain register port (read data valid one cycle after the strobe).
*/
// Implementation choices: strobed register access and the register offsets.
// Overview of operation
// - After reset measurement is off and the route switch is open.
// - The switch closes only while measurement is enabled and the mode is Normal.
// - Entering Fail-Safe keeps the enable bit but forces the switch open.
// - With measurement off, Fail-Safe entry makes the high-voltage wake input a wake source.
// - Measurement on turns off pull currents on both pins.
// - Measurement on gates pin inputs and freezes wake and level status.
// - Pull, wake control and GPIO writes are stored but ineffective during measurement.
// - Wake enables stay writable but produce no wake-ups during measurement.
// - Sleep request with measurement on and only pin wake sources sets error and restarts.
// - Measurement on removes fail-output, its test, GPIO and wake functions.
// - Changing the GPIO pin function during measurement sets the command error flag.
// - Enable is refused with error unless the GPIO pin function is Off.
module hvm_route_ctrl
  import hvm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Mode controller
  input wire logic [2:0] opMode,
  input wire logic sleepReq,
  input wire logic otherWakeSrc,
  output logic restartReq,
  output logic sleepGrant,
  // Pins
  input wire logic hvWakeIn,
  input wire logic gpioIn,
  output logic measureRouteSwitch,
  output logic hvPullUp,
  output logic hvPullDown,
  output logic gpioPullUp,
  output logic gpioPullDown,
  output logic failOutput,
  output logic gpioOut,
  output logic gpioOe,
  output logic wakeIrq
);

  // Configuration and status state.
  logic measEn_ff, nxt_measEn;
  logic [7:0] pull_ff, nxt_pull;
  logic [7:0] wakeCtrl_ff, nxt_wakeCtrl;
  logic [7:0] gpioCfg_ff, nxt_gpioCfg;
  logic [7:0] stat0_ff, nxt_stat0;
  logic [7:0] stat1_ff, nxt_stat1;
  logic [7:0] lvl_ff, nxt_lvl;
  logic cmdErr_ff, nxt_cmdErr;
  logic fsWake_ff, nxt_fsWake;
  logic [2:0] mode_ff;
  logic [7:0] rdata_ff, nxt_rdata;
  // Pin-function and handshake outputs, each from its own flip-flop.
  logic switch_ff, nxt_switch;
  logic restart_ff, nxt_restart;
  logic grant_ff, nxt_grant;
  logic fo_ff, nxt_fo;
  logic gOut_ff, nxt_gOut;
  logic gOe_ff, nxt_gOe;
  logic irq_ff, nxt_irq;
  // Per-pin results and decoded strobes.
  logic hvWakeEv, gpWakeEv, hvLvl, gpLvl, hvLvlOk, gpLvlOk;
  logic [2:0] gpioFn;
  logic wrMeas, wrGpio, failSafeEntry, errSet, errClr;

  // Decode a write strobe for one register index.
  function automatic logic wr_hit(
    input logic [ADDR_W-1:0] a,
    input logic [3:0] idx,
    input logic w
  );
    wr_hit = w && (a == idx);
  endfunction

  // Shared strobe and mode decodes; the mode is registered so entry lasts one cycle.
  assign gpioFn = gpioCfg_ff[GPIO_FN_LSB +: 3];
  assign wrMeas = wr_hit(regAddr, REG_MEAS_CTRL, regWrite);
  assign wrGpio = wr_hit(regAddr, REG_GPIO_CFG, regWrite);
  assign failSafeEntry = (opMode == MODE_FAILSAFE) && (mode_ff != MODE_FAILSAFE);

  // Per-pin wake detection; the gate blocks events and level updates while the reference keeps tracking.
  hvm_wake_detect uHvWake (
    .core_clk(core_clk),
    .reset(reset),
    .pinIn(hvWakeIn),
    .wakeEn(wakeCtrl_ff[BIT_WAKE_EN] || fsWake_ff),
    .gateOn(measEn_ff),
    .wakeEvent(hvWakeEv),
    .levelOut(hvLvl),
    .levelValid(hvLvlOk)
  );

  // Both pins share one gate, so they leave measurement in the same cycle.
  hvm_wake_detect uGpioWake (
    .core_clk(core_clk),
    .reset(reset),
    .pinIn(gpioIn),
    .wakeEn(gpioFn == GPIO_FN_WAKE),
    .gateOn(measEn_ff),
    .wakeEvent(gpWakeEv),
    .levelOut(gpLvl),
    .levelValid(gpLvlOk)
  );

  // Pull-current decoders; the stored setting stays but is overridden.
  hvm_pull_ctrl uHvPull (
    .core_clk(core_clk),
    .reset(reset),
    .pullSel(pull_ff[PULL_HV_LSB +: 2]),
    .levelIn(hvWakeIn),
    .measOn(measEn_ff),
    .pullUpEn(hvPullUp),
    .pullDownEn(hvPullDown)
  );

  hvm_pull_ctrl uGpioPull (
    .core_clk(core_clk),
    .reset(reset),
    .pullSel(pull_ff[PULL_GPIO_LSB +: 2]),
    .levelIn(gpioIn),
    .measOn(measEn_ff),
    .pullUpEn(gpioPullUp),
    .pullDownEn(gpioPullDown)
  );

  // Command error: set wins over a software clear (write one to clear).
  // Each refusal only raises the flag; what happens to the write itself is decided below.
  always_comb
  begin
    errClr = wr_hit(regAddr, REG_STATUS, regWrite) && regWdata[BIT_CMD_ERR];
    errSet = 1'b0;
    if (wrMeas && regWdata[BIT_MEAS_EN] && !measEn_ff && gpioFn != GPIO_FN_OFF)
      errSet = 1'b1;
    if (wrGpio && measEn_ff && regWdata[GPIO_FN_LSB +: 3] != gpioFn)
      errSet = 1'b1;
    if (sleepReq && measEn_ff && !otherWakeSrc)
      errSet = 1'b1;
    nxt_cmdErr = errSet || (cmdErr_ff && !errClr);
  end

  // Configuration registers: pull, wake and GPIO writes always land, effect is gated elsewhere.
  // A refused enable leaves the bit at zero, so a retry after switching the pin Off works.
  always_comb
  begin
    nxt_measEn = measEn_ff;
    nxt_pull = pull_ff;
    nxt_wakeCtrl = wakeCtrl_ff;
    nxt_gpioCfg = gpioCfg_ff;
    if (wrMeas)
    begin
      if (!regWdata[BIT_MEAS_EN])
        nxt_measEn = 1'b0;
      else if (gpioFn == GPIO_FN_OFF)
        nxt_measEn = 1'b1;
    end
    if (wr_hit(regAddr, REG_WAKE_PULL, regWrite))
      nxt_pull = regWdata;
    if (wr_hit(regAddr, REG_WAKE_CTRL, regWrite))
      nxt_wakeCtrl = regWdata;
    if (wrGpio)
      nxt_gpioCfg = regWdata;
  end

  // Wake status: sticky, set wins over write-one-to-clear; level status follows the pin; both frozen when gated.
  // Hardware sets come after the clears, so an event in the clearing cycle is never lost.
  always_comb
  begin
    nxt_stat0 = stat0_ff;
    nxt_stat1 = stat1_ff;
    nxt_lvl = lvl_ff;
    if (wr_hit(regAddr, REG_WAKE_STAT0, regWrite))
      nxt_stat0 = stat0_ff & ~regWdata;
    if (wr_hit(regAddr, REG_WAKE_STAT1, regWrite))
      nxt_stat1 = stat1_ff & ~regWdata;
    if (hvWakeEv)
      nxt_stat0[BIT_HV_WAKE] = 1'b1;
    if (gpWakeEv)
      nxt_stat1[BIT_GPIO_WAKE] = 1'b1;
    if (hvLvlOk)
      nxt_lvl[BIT_HV_WAKE] = hvLvl;
    if (gpLvlOk)
      nxt_lvl[BIT_GPIO_WAKE] = gpLvl;
  end

  // Fail-Safe wake activation, held until Fail-Safe is left.
  // It is cleared by leaving the mode, not by software, so no write can cancel it early.
  always_comb
  begin
    nxt_fsWake = fsWake_ff;
    if (failSafeEntry && !measEn_ff)
      nxt_fsWake = 1'b1;
    else if (opMode != MODE_FAILSAFE)
      nxt_fsWake = 1'b0;
  end

  // Pin outputs: switch follows enable and mode every cycle; functions gated by measurement.
  // The live mode is used, not mode_ff, so the switch opens one cycle after Normal is left.
  // Only the fail-output function drives the pin here; other GPIO functions lie elsewhere.
  always_comb
  begin
    nxt_switch = measEn_ff && (opMode == MODE_NORMAL);
    nxt_fo = !measEn_ff && (gpioFn == GPIO_FN_FAILOUT)
             && ((opMode == MODE_FAILSAFE) || wakeCtrl_ff[BIT_FO_TEST]);
    nxt_gOe = !measEn_ff && (gpioFn == GPIO_FN_FAILOUT);
    nxt_gOut = nxt_fo;
    nxt_irq = hvWakeEv || gpWakeEv;
    nxt_restart = sleepReq && measEn_ff && !otherWakeSrc;
    nxt_grant = sleepReq && !(measEn_ff && !otherWakeSrc);
  end

  // Register read data, one cycle after the strobe.
  // Reads have no side effects, so a polling host cannot lose a flag.
  always_comb
  begin
    nxt_rdata = RST_ZERO;
    if (regRead)
    begin
      case (regAddr)
        REG_MEAS_CTRL: nxt_rdata[BIT_MEAS_EN] = measEn_ff;
        REG_WAKE_PULL: nxt_rdata = pull_ff;
        REG_WAKE_CTRL: nxt_rdata = wakeCtrl_ff;
        REG_GPIO_CFG: nxt_rdata = gpioCfg_ff;
        REG_WAKE_STAT0: nxt_rdata = stat0_ff;
        REG_WAKE_STAT1: nxt_rdata = stat1_ff;
        REG_WAKE_LVL: nxt_rdata = lvl_ff;
        REG_STATUS:
        begin
          nxt_rdata[BIT_CMD_ERR] = cmdErr_ff;
          nxt_rdata[BIT_SWITCH] = switch_ff;
          nxt_rdata[BIT_FAILSAFE_WK] = fsWake_ff;
        end
        default: nxt_rdata = RST_ZERO;
      endcase
    end
  end

  // All state registers; reset leaves measurement off and the switch open.
  // Only constants appear in the reset branch, keeping the asynchronous path free of logic.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      measEn_ff <= 1'b0;
      switch_ff <= 1'b0;
      pull_ff <= RST_ZERO;
      wakeCtrl_ff <= RST_ZERO;
      gpioCfg_ff <= RST_GPIO_CFG;
      stat0_ff <= RST_ZERO;
      stat1_ff <= RST_ZERO;
      lvl_ff <= RST_ZERO;
      cmdErr_ff <= 1'b0;
      fsWake_ff <= 1'b0;
      mode_ff <= MODE_INIT;
      rdata_ff <= RST_ZERO;
      restart_ff <= 1'b0;
      grant_ff <= 1'b0;
      fo_ff <= 1'b0;
      gOut_ff <= 1'b0;
      gOe_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      measEn_ff <= nxt_measEn;
      switch_ff <= nxt_switch;
      pull_ff <= nxt_pull;
      wakeCtrl_ff <= nxt_wakeCtrl;
      gpioCfg_ff <= nxt_gpioCfg;
      stat0_ff <= nxt_stat0;
      stat1_ff <= nxt_stat1;
      lvl_ff <= nxt_lvl;
      cmdErr_ff <= nxt_cmdErr;
      fsWake_ff <= nxt_fsWake;
      mode_ff <= opMode;
      rdata_ff <= nxt_rdata;
      restart_ff <= nxt_restart;
      grant_ff <= nxt_grant;
      fo_ff <= nxt_fo;
      gOut_ff <= nxt_gOut;
      gOe_ff <= nxt_gOe;
      irq_ff <= nxt_irq;
    end
  end

  // Ports read the flip-flops directly, so no output carries a combinational glitch.
  assign regRdata = rdata_ff;
  assign measureRouteSwitch = switch_ff;
  assign restartReq = restart_ff;
  assign sleepGrant = grant_ff;
  assign failOutput = fo_ff;
  assign gpioOut = gOut_ff;
  assign gpioOe = gOe_ff;
  assign wakeIrq = irq_ff;

endmodule

//--- rtl/hvm_pkg.sv
/*
  Package for the high-voltage measurement route control block.
  Holds register indices, field positions, reset values, mode and pin-function encodings.
  Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package hvm_pkg;

  // Operating modes as reported by the mode controller.
  localparam logic [2:0] MODE_INIT = 3'h0;
  localparam logic [2:0] MODE_NORMAL = 3'h1;
  localparam logic [2:0] MODE_STOP = 3'h2;
  localparam logic [2:0] MODE_SLEEP = 3'h3;
  localparam logic [2:0] MODE_RESTART = 3'h4;
  localparam logic [2:0] MODE_FAILSAFE = 3'h5;

  // Register indices on the plain register port.
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_MEAS_CTRL = 4'h0;
  localparam logic [3:0] REG_WAKE_PULL = 4'h1;
  localparam logic [3:0] REG_WAKE_CTRL = 4'h2;
  localparam logic [3:0] REG_GPIO_CFG = 4'h3;
  localparam logic [3:0] REG_WAKE_STAT0 = 4'h4;
  localparam logic [3:0] REG_WAKE_STAT1 = 4'h5;
  localparam logic [3:0] REG_WAKE_LVL = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;

  // Field positions.
  localparam int BIT_MEAS_EN = 0;
  localparam int BIT_WAKE_EN = 0;
  localparam int BIT_FO_TEST = 1;
  localparam int BIT_HV_WAKE = 0;
  localparam int BIT_GPIO_WAKE = 1;
  localparam int BIT_CMD_ERR = 0;
  localparam int BIT_SWITCH = 1;
  localparam int BIT_FAILSAFE_WK = 2;
  localparam int GPIO_FN_LSB = 0;
  localparam int PULL_HV_LSB = 0;
  localparam int PULL_GPIO_LSB = 2;

  // GPIO pin function encodings.
  localparam logic [2:0] GPIO_FN_FAILOUT = 3'h0;
  localparam logic [2:0] GPIO_FN_WAKE = 3'h5;
  localparam logic [2:0] GPIO_FN_OFF = 3'h6;

  // Pull encodings: 0 none, 1 down, 2 up, 3 automatic.
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;

  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_GPIO_CFG = 8'h00;

endpackage

//--- rtl/hvm_pull_ctrl.sv
/*
  Pull-current decoder for one high-voltage pin.
  Assumes the pull setting and the measure state are registered upstream.
*/
module hvm_pull_ctrl
  import hvm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Setting and override
  input wire logic [1:0] pullSel,
  input wire logic levelIn,
  input wire logic measOn,
  // Pull current enables
  output logic pullUpEn,
  output logic pullDownEn
);

  logic pullUp_ff;
  logic pullDown_ff;
  logic nxt_pullUp;
  logic nxt_pullDown;

  // Automatic mode pulls toward the present level; measurement kills both currents.
  always_comb
  begin
    nxt_pullUp = 1'b0;
    nxt_pullDown = 1'b0;
    if (!measOn)
    begin
      case (pullSel)
        PULL_NONE: nxt_pullUp = 1'b0;
        PULL_DOWN: nxt_pullDown = 1'b1;
        PULL_UP: nxt_pullUp = 1'b1;
        default:
        begin
          nxt_pullUp = levelIn;
          nxt_pullDown = !levelIn;
        end
      endcase
    end
  end

  // Registered so the top can pass these straight to its ports.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pullUp_ff <= 1'b0;
      pullDown_ff <= 1'b0;
    end
    else
    begin
      pullUp_ff <= nxt_pullUp;
      pullDown_ff <= nxt_pullDown;
    end
  end

  assign pullUpEn = pullUp_ff;
  assign pullDownEn = pullDown_ff;

endmodule

//--- rtl/hvm_wake_detect.sv
/*
  Edge-to-wake detector for one pin, gated by the measurement function.
  Assumes pin inputs are synchronous to core_clk.
*/
module hvm_wake_detect
  import hvm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pin and control
  input wire logic pinIn,
  input wire logic wakeEn,
  input wire logic gateOn,
  // Results
  output logic wakeEvent,
  output logic levelOut,
  output logic levelValid
);

  logic prev_ff;
  logic nxt_prev;

  // Track the pin even while gated, so lifting the gate never shows a stale edge.
  always_comb
  begin
    nxt_prev = pinIn;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      prev_ff <= 1'b0;
    else
      prev_ff <= nxt_prev;
  end

  assign wakeEvent = wakeEn && !gateOn && (pinIn != prev_ff);
  assign levelOut = pinIn;
  assign levelValid = !gateOn;

endmodule

//--- sim/hvm_route_chk.sv
/*
  Port checker for the measurement route control block.
  Assumes it is bound to hvm_route_ctrl and sees only its ports.
*/
module hvm_route_chk
  import hvm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Mode controller
  input wire logic [2:0] opMode,
  input wire logic sleepReq,
  input wire logic otherWakeSrc,
  input wire logic restartReq,
  input wire logic sleepGrant,
  // Pins
  input wire logic measureRouteSwitch,
  input wire logic hvPullUp,
  input wire logic hvPullDown,
  input wire logic gpioPullUp,
  input wire logic gpioPullDown,
  input wire logic failOutput,
  input wire logic gpioOe,
  input wire logic wakeIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // A closed switch implies measurement on, so it doubles as the enable seen from outside.
  AST_SW_NORMAL: assert property (measureRouteSwitch |-> $past(opMode) == MODE_NORMAL)
    else $error("switch closed outside Normal mode");
  AST_SW_FAILSAFE: assert property (opMode == MODE_FAILSAFE |=> !measureRouteSwitch)
    else $error("switch closed in Fail-Safe mode");
  AST_SW_RESET: assert property ($fell(reset) |-> !measureRouteSwitch [*2])
    else $error("switch closed right after reset");
  AST_PULL_OFF: assert property (measureRouteSwitch |->
    !(hvPullUp || hvPullDown || gpioPullUp || gpioPullDown))
    else $error("pull current on during measurement");
  AST_PIN_QUIET: assert property (measureRouteSwitch |-> !failOutput && !gpioOe)
    else $error("pin function active during measurement");
  AST_NO_WAKE: assert property (measureRouteSwitch && $past(measureRouteSwitch) |-> !wakeIrq)
    else $error("wake during measurement");
  AST_RESTART: assert property (sleepReq && measureRouteSwitch && !otherWakeSrc |=>
    restartReq && !sleepGrant)
    else $error("refused sleep did not restart");
  AST_RESTART_CAUSE: assert property (restartReq |-> $past(sleepReq))
    else $error("restart without sleep command");
endmodule

//--- sim/hvm_host_model.sv
/*
  Host model: the register master that configures the block.
  Assumes one clock shared with the device; read data stand one cycle.
*/
module hvm_host_model
  import hvm_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [ADDR_W-1:0] regAddr,
  output logic [7:0] regWdata,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle values before the first request.
  initial
  begin
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  // One-cycle write; data are inverted afterwards so stale data are never mistaken for valid.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask

  // One-cycle read; data are taken in the following cycle only.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
endmodule

//--- sim/tb_top.sv
/*
  Self-checking bench for hvm_route_ctrl.
  Assumes the host model and the port checker are compiled before it.
*/
module tb_top
  import hvm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [2:0] mode; logic sw;} hvm_row_t;
  logic core_clk, reset, regWrite, regRead, sleepReq, otherWakeSrc, hvWakeIn, gpioIn;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, rd;
  logic [2:0] opMode;
  logic restartReq, sleepGrant, measureRouteSwitch, hvPullUp, hvPullDown;
  logic gpioPullUp, gpioPullDown, failOutput, gpioOut, gpioOe, wakeIrq, seen;
  int bad_count = 0;
  int tests_run = 0;
  hvm_row_t rows [6] = '{'{MODE_NORMAL, 1'b1}, '{MODE_STOP, 1'b0}, '{MODE_SLEEP, 1'b0},
    '{MODE_RESTART, 1'b0}, '{MODE_FAILSAFE, 1'b0}, '{MODE_INIT, 1'b0}};

  hvm_route_ctrl uut (.*);
  hvm_host_model host (.*);

  // Free-running core clock.
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Looks for a wake pulse over a few cycles, enough for edge plus register delay.
  task automatic watch_irq(output logic s);
    s = 1'b0;
    repeat (6)
    begin
      @(posedge core_clk);
      #1;
      s |= wakeIrq;
    end
  endtask

  task automatic sleep_cmd;
    @(posedge core_clk) sleepReq <= 1'b1;
    @(posedge core_clk) sleepReq <= 1'b0;
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    {reset, sleepReq, otherWakeSrc, hvWakeIn, gpioIn} = 5'h10;
    opMode = MODE_NORMAL;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    tick(1);
    chk("switch", measureRouteSwitch, 0);
    host.rd(REG_STATUS, rd);
    chk("status", rd, 0);
    host.rd(REG_GPIO_CFG, rd);
    chk("gpio cfg", rd, RST_GPIO_CFG);
    host.wr(REG_MEAS_CTRL, 8'h01);
    host.rd(REG_MEAS_CTRL, rd);
    chk("meas refused", rd, 0);
    host.rd(REG_STATUS, rd);
    chk("err", rd[BIT_CMD_ERR], 1);
    host.wr(REG_STATUS, 8'h01);
    host.wr(REG_GPIO_CFG, {5'h00, GPIO_FN_OFF});
    host.wr(REG_WAKE_PULL, 8'h0B);
    host.wr(REG_WAKE_CTRL, 8'h01);
    tick(1);
    chk("pulls cfg", {hvPullUp, hvPullDown, gpioPullUp, gpioPullDown}, 4'h6);
    @(posedge core_clk) hvWakeIn <= 1'b1;
    watch_irq(seen);
    chk("wake off", seen, 1);
    chk("auto pull", {hvPullUp, hvPullDown}, 2'h2);
    host.wr(REG_WAKE_STAT0, 8'h01);
    host.wr(REG_MEAS_CTRL, 8'h01);
    tick(1);
    chk("switch on", measureRouteSwitch, 1);
    chk("pulls", {hvPullUp, hvPullDown, gpioPullUp, gpioPullDown}, 0);
    // A reset in mid-run must open a closed switch and drop the enable with it.
    @(posedge core_clk) reset <= 1'b1;
    @(posedge core_clk) reset <= 1'b0;
    tick(1);
    chk("reset switch", measureRouteSwitch, 0);
    host.rd(REG_MEAS_CTRL, rd);
    chk("reset meas", rd, 0);
    host.wr(REG_GPIO_CFG, {5'h00, GPIO_FN_OFF});
    host.wr(REG_WAKE_CTRL, 8'h01);
    host.wr(REG_MEAS_CTRL, 8'h01);
    tick(2);
    chk("switch again", measureRouteSwitch, 1);
    // Each mode must open or close the switch while the enable bit stays put.
    foreach (rows[i])
    begin
      @(posedge core_clk) opMode <= rows[i].mode;
      tick(2);
      chk("mode switch", measureRouteSwitch, rows[i].sw);
      host.rd(REG_MEAS_CTRL, rd);
      chk("meas kept", rd[BIT_MEAS_EN], 1);
    end
    @(posedge core_clk) opMode <= MODE_NORMAL;
    @(posedge core_clk) hvWakeIn <= 1'b0;
    gpioIn <= 1'b1;
    watch_irq(seen);
    chk("wake gated", seen, 0);
    host.rd(REG_WAKE_STAT0, rd);
    chk("stat frozen", rd, 0);
    host.rd(REG_WAKE_LVL, rd);
    chk("lvl frozen", rd, 8'h01);
    host.wr(REG_GPIO_CFG, {5'h00, GPIO_FN_FAILOUT});
    host.wr(REG_WAKE_CTRL, 8'h03);
    tick(1);
    chk("no fo", {failOutput, gpioOe}, 0);
    host.rd(REG_GPIO_CFG, rd);
    chk("cfg stored", rd, GPIO_FN_FAILOUT);
    host.rd(REG_STATUS, rd);
    chk("gpio err", rd[BIT_CMD_ERR], 1);
    host.wr(REG_STATUS, 8'h01);
    sleep_cmd();
    chk("restart", {restartReq, sleepGrant}, 2);
    host.rd(REG_STATUS, rd);
    chk("sleep err", rd[BIT_CMD_ERR], 1);
    @(posedge core_clk) otherWakeSrc <= 1'b1;
    sleep_cmd();
    chk("grant", {restartReq, sleepGrant}, 1);
    host.wr(REG_MEAS_CTRL, 8'h00);
    watch_irq(seen);
    chk("no stale wake", seen, 0);
    chk("fo back", {failOutput, gpioOe, gpioOut}, 3'h7);
    @(posedge core_clk) opMode <= MODE_FAILSAFE;
    host.rd(REG_STATUS, rd);
    chk("fs wake", rd[BIT_FAILSAFE_WK], 1);
    print_verdict();
  end

  // Cuts a hang short; the sequence needs well under a thousand cycles.
  initial
  begin
    #(50 * 4000);
    bad_count++;
    print_verdict();
  end
endmodule

bind hvm_route_ctrl hvm_route_chk chk_i (.*);
